// ### hdl/gole_pkg.sv
// Purpose: Constants and types for the port output, lock and event block
// Assumes: 32-bit AXI4-Lite register access, 16 pins per port
// Notes:   Offsets are byte addresses
`default_nettype none
package gole_pkg;
    localparam int unsigned GOLE_AW      = 8;
    localparam int unsigned GOLE_PINS    = 16;
    // Register byte offsets
    localparam logic [7:0] OFS_ROUTE     = 8'h00;
    localparam logic [7:0] OFS_LEVEL     = 8'h0C;
    localparam logic [7:0] OFS_SETCLR    = 8'h10;
    localparam logic [7:0] OFS_CLRONLY   = 8'h14;
    localparam logic [7:0] OFS_LOCK      = 8'h18;
    localparam logic [7:0] OFS_CFG_LO    = 8'h20;
    localparam logic [7:0] OFS_CFG_HI    = 8'h24;
    // Reset values
    localparam logic [7:0]  RST_ROUTE    = 8'h00;
    localparam logic [15:0] RST_LEVEL    = 16'h0000;
    localparam logic [15:0] RST_LOCK     = 16'h0000;
    localparam logic [31:0] RST_CFG      = 32'h0000_0000;
    // Field positions
    localparam int unsigned KEY_BIT      = 16;
    localparam int unsigned CLR_LSB      = 16;
    localparam int unsigned ROUTE_EN_BIT = 7;
    localparam int unsigned PORT_LSB     = 4;
    localparam int unsigned PORT_W       = 3;
    localparam int unsigned PIN_SEL_W    = 4;
    localparam int unsigned FIELD_W      = 4;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [3:0]  STRB_FULL    = 4'hF;

    typedef enum logic [3:0] {
        KS_IDLE  = 4'h1,
        KS_ONE   = 4'h2,
        KS_ZERO  = 4'h4,
        KS_ARMED = 4'h8
    } gole_key_t;

    typedef enum logic [2:0] {
        SEL_ROUTE, SEL_LEVEL, SEL_SETCLR, SEL_CLRONLY,
        SEL_LOCK, SEL_CFG_LO, SEL_CFG_HI, SEL_NONE
    } gole_sel_t;
endpackage
`default_nettype wire

// ### hdl/gole_top.sv
// Purpose: Port output level, bit set/clear, config lock, event routing
// Assumes: Single 20 MHz clock, word-only AXI4-Lite access
// Notes:   Pin level, mode and config outputs all come from flip-flops
`default_nettype none
module gole_top
    import gole_pkg::*;
#(
    parameter logic [2:0] PORT_ID = 3'h0
) (
    // Clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    // AXI4-Lite write address
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [GOLE_AW-1:0]   i_awaddr,
    input  wire logic [2:0]           i_awprot,
    // AXI4-Lite write data
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    // AXI4-Lite write response
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    output logic [1:0]                o_bresp,
    // AXI4-Lite read address
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    input  wire logic [GOLE_AW-1:0]   i_araddr,
    input  wire logic [2:0]           i_arprot,
    // AXI4-Lite read data
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    // Event source
    input  wire logic                 i_cpu_event_pulse,
    // Pin side
    output logic [GOLE_PINS-1:0]      o_pin_level,
    output logic [2*GOLE_PINS-1:0]    o_pin_mode_field,
    output logic [2*GOLE_PINS-1:0]    o_pin_cfg_field,
    output logic                      o_lock_key_bit
);

    // Whole module state, registered as one word
    typedef struct packed {
        logic                  aw_have;
        logic [GOLE_AW-1:0]    aw_addr;
        logic                  w_have;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  b_valid;
        logic [1:0]            b_resp;
        logic                  r_valid;
        logic [31:0]           r_data;
        logic [1:0]            r_resp;
        logic [15:0]           out_level_bits;
        logic [7:0]            route;
        logic [15:0]           pin_lock_bits;
        logic                  lock_key_bit;
        gole_key_t             key_state;
        logic [31:0]           cfg_lo;
        logic [31:0]           cfg_hi;
        logic [15:0]           pin;
    } gole_state_t;

    // Every field resets to a constant
    localparam gole_state_t STATE_RST = '{
        aw_have:        1'b0,
        aw_addr:        '0,
        w_have:         1'b0,
        w_data:         32'h0000_0000,
        w_strb:         4'h0,
        b_valid:        1'b0,
        b_resp:         RESP_OKAY,
        r_valid:        1'b0,
        r_data:         32'h0000_0000,
        r_resp:         RESP_OKAY,
        out_level_bits: RST_LEVEL,
        route:          RST_ROUTE,
        pin_lock_bits:  RST_LOCK,
        lock_key_bit:   1'b0,
        key_state:      KS_IDLE,
        cfg_lo:         RST_CFG,
        cfg_hi:         RST_CFG,
        pin:            RST_LEVEL
    };

    gole_state_t s_q;
    gole_state_t s_d;

    // Map a byte address onto a register
    function automatic gole_sel_t reg_sel(input logic [GOLE_AW-1:0] addr);
        unique case (addr)
            OFS_ROUTE: begin
                reg_sel = SEL_ROUTE;
            end
            OFS_LEVEL: begin
                reg_sel = SEL_LEVEL;
            end
            OFS_SETCLR: begin
                reg_sel = SEL_SETCLR;
            end
            OFS_CLRONLY: begin
                reg_sel = SEL_CLRONLY;
            end
            OFS_LOCK: begin
                reg_sel = SEL_LOCK;
            end
            OFS_CFG_LO: begin
                reg_sel = SEL_CFG_LO;
            end
            OFS_CFG_HI: begin
                reg_sel = SEL_CFG_HI;
            end
            default: begin
                reg_sel = SEL_NONE;
            end
        endcase
    endfunction

    // Widen eight pin locks into a field mask, four bits per pin
    function automatic logic [31:0] field_mask(input logic [7:0] locks,
                                               input logic       key);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            m[i*FIELD_W +: FIELD_W] = {FIELD_W{locks[i] & key}};
        end
        field_mask = m;
    endfunction

    // A key=1 write counts as the first step of a new sequence unless it completes one from KS_ZERO
    function automatic gole_key_t key_restart(input logic key);
        if (key) begin
            key_restart = KS_ONE;
        end else begin
            key_restart = KS_IDLE;
        end
    endfunction

    // Combinational helpers, recomputed every cycle
    gole_sel_t   wsel;
    gole_sel_t   rsel;
    logic        do_write;
    logic        do_read;
    logic        word_ok;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [31:0] mask_lo;
    logic [31:0] mask_hi;
    logic        wr_key;
    logic [15:0] wr_lk;
    logic        same_lk;

    // Handshake outputs
    assign o_awready = ~s_q.aw_have;
    assign o_wready  = ~s_q.w_have;
    assign o_arready = ~s_q.r_valid;

    always_comb begin
        s_d      = s_q;

        // Decode the held write and the offered read
        wsel     = reg_sel(s_q.aw_addr);
        rsel     = reg_sel(i_araddr);
        do_write = s_q.aw_have & s_q.w_have & ~s_q.b_valid;
        do_read  = i_arvalid & ~s_q.r_valid;
        word_ok  = (s_q.w_strb == STRB_FULL);
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        wr_key   = s_q.w_data[KEY_BIT];
        wr_lk    = s_q.w_data[15:0];
        same_lk  = (wr_lk == s_q.pin_lock_bits);
        // Locked pin fields are held over a config write once the key bit is set
        mask_lo  = field_mask(s_q.pin_lock_bits[7:0], s_q.lock_key_bit);
        mask_hi  = field_mask(s_q.pin_lock_bits[15:8], s_q.lock_key_bit);

        // Capture address and data independently
        if (i_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = i_awaddr;
        end

        if (i_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = i_wdata;
            s_d.w_strb = i_wstrb;
        end

        if (s_q.b_valid && i_bready) begin
            s_d.b_valid = 1'b0;
        end

        // Execute once both halves are held and no answer waits
        if (do_write) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.b_valid = 1'b1;
            s_d.b_resp  = RESP_OKAY;

            if (!word_ok || wsel == SEL_NONE) begin
                s_d.b_resp = RESP_SLVERR;
            end else begin
                unique case (wsel)
                    SEL_ROUTE: begin
                        s_d.route = s_q.w_data[7:0];
                    end
                    SEL_LEVEL: begin
                        s_d.out_level_bits = wr_lk;
                    end
                    SEL_SETCLR: begin
                        // Low half sets, high half clears
                        set_bits = s_q.w_data[15:0];
                        clr_bits = s_q.w_data[CLR_LSB +: 16];
                    end
                    SEL_CLRONLY: begin
                        clr_bits = s_q.w_data[15:0];
                    end
                    SEL_LOCK: begin
                        // A set key freezes everything here
                        if (!s_q.lock_key_bit) begin
                            s_d.pin_lock_bits = wr_lk;
                            unique case (s_q.key_state)
                                KS_ONE: begin
                                    if (!wr_key && same_lk) begin
                                        s_d.key_state = KS_ZERO;
                                    end else begin
                                        s_d.key_state =
                                            key_restart(wr_key);
                                    end
                                end
                                KS_ZERO: begin
                                    if (wr_key && same_lk) begin
                                        s_d.key_state = KS_ARMED;
                                    end else begin
                                        s_d.key_state =
                                            key_restart(wr_key);
                                    end
                                end
                                default: begin
                                    s_d.key_state =
                                        key_restart(wr_key);
                                end
                            endcase
                        end
                    end
                    SEL_CFG_LO: begin
                        s_d.cfg_lo = (s_q.cfg_lo & mask_lo) |
                                     (s_q.w_data & ~mask_lo);
                    end
                    SEL_CFG_HI: begin
                        s_d.cfg_hi = (s_q.cfg_hi & mask_hi) |
                                     (s_q.w_data & ~mask_hi);
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Per-bit update, set after clear so set wins
        s_d.out_level_bits = (s_d.out_level_bits & ~clr_bits)
                             | set_bits;

        if (s_q.r_valid && i_rready) begin
            s_d.r_valid = 1'b0;
        end

        // Reads answer from the registered state
        if (do_read) begin
            s_d.r_valid = 1'b1;
            s_d.r_resp  = RESP_OKAY;
            s_d.r_data  = 32'h0000_0000;
            unique case (rsel)
                SEL_ROUTE: begin
                    s_d.r_data[7:0]  = s_q.route;
                end
                SEL_LEVEL: begin
                    s_d.r_data[15:0] = s_q.out_level_bits;
                end
                SEL_LOCK: begin
                    s_d.r_data[15:0]    = s_q.pin_lock_bits;
                    s_d.r_data[KEY_BIT] = s_q.lock_key_bit;
                    if (!s_q.lock_key_bit) begin
                        // First read after the writes shows 0, then key
                        if (s_q.key_state == KS_ARMED) begin
                            s_d.lock_key_bit = 1'b1;
                        end
                        s_d.key_state = KS_IDLE;
                    end
                end
                SEL_CFG_LO: begin
                    s_d.r_data = s_q.cfg_lo;
                end
                SEL_CFG_HI: begin
                    s_d.r_data = s_q.cfg_hi;
                end
                SEL_NONE: begin
                    s_d.r_resp = RESP_SLVERR;
                end
                default: begin
                end
            endcase
        end

        // Pin levels follow the level register, event may take one pin
        s_d.pin = s_d.out_level_bits;
        if (s_d.route[ROUTE_EN_BIT] &&
            s_d.route[PORT_LSB +: PORT_W] == PORT_ID) begin
            s_d.pin[s_d.route[PIN_SEL_W-1:0]] = i_cpu_event_pulse;
        end
    end

    // One register holds the whole state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Split the four-bit per-pin field into mode and config
    for (genvar g = 0; g < GOLE_PINS; g++) begin : g_field
        localparam int unsigned B = (g % 8) * FIELD_W;
        if (g < 8) begin : g_lo
            assign o_pin_mode_field[2*g +: 2] = s_q.cfg_lo[B +: 2];
            assign o_pin_cfg_field[2*g +: 2]  = s_q.cfg_lo[B+2 +: 2];
        end else begin : g_hi
            assign o_pin_mode_field[2*g +: 2] = s_q.cfg_hi[B +: 2];
            assign o_pin_cfg_field[2*g +: 2]  = s_q.cfg_hi[B+2 +: 2];
        end
    end

    // Registered bus answers
    assign o_bvalid       = s_q.b_valid;
    assign o_bresp        = s_q.b_resp;
    assign o_rvalid       = s_q.r_valid;
    assign o_rdata        = s_q.r_data;
    assign o_rresp        = s_q.r_resp;

    // Registered pin side
    assign o_pin_level    = s_q.pin;
    assign o_lock_key_bit = s_q.lock_key_bit;

endmodule
`default_nettype wire

// ### test/gole_props.sv
// Purpose: Concurrent checks on the gole_top ports
// Assumes: Write address and data are offered in the same cycle
// Notes:   A write lands two edges after its handshake
`default_nettype none
module gole_props
    import gole_pkg::*;
#(
    parameter logic [2:0] PORT_ID = 3'h0
) (
    // Clock and reset
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst,
    // Register bus
    input wire logic                 i_awvalid,
    input wire logic                 o_awready,
    input wire logic [GOLE_AW-1:0]   i_awaddr,
    input wire logic                 i_wvalid,
    input wire logic                 o_wready,
    input wire logic [31:0]          i_wdata,
    input wire logic [3:0]           i_wstrb,
    input wire logic                 o_bvalid,
    input wire logic [1:0]           o_bresp,
    input wire logic                 i_arvalid,
    input wire logic                 o_arready,
    input wire logic [GOLE_AW-1:0]   i_araddr,
    input wire logic                 o_rvalid,
    input wire logic [31:0]          o_rdata,
    // Pins
    input wire logic                 i_cpu_event_pulse,
    input wire logic [GOLE_PINS-1:0] o_pin_level,
    input wire logic                 o_lock_key_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        aw_w;
    logic        wr_go;
    logic        ar_lock;
    logic        wv_q;
    logic [7:0]  wa_q;
    logic [7:0]  wd_q;
    logic [7:0]  route_q;
    logic [15:0] msk;
    assign aw_w    = i_awvalid && o_awready && i_wvalid && o_wready;
    assign wr_go   = aw_w && i_wstrb == STRB_FULL;
    assign ar_lock = i_arvalid && o_arready && i_araddr == OFS_LOCK;
    // Pin carrying the event pulse is left out of level checks
    assign msk = (route_q[7] && route_q[6:4] == PORT_ID)
                 ? ~(16'h0001 << route_q[3:0]) : 16'hFFFF;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wv_q    <= 1'b0;
            wa_q    <= 8'h00;
            wd_q    <= 8'h00;
            route_q <= 8'h00;
        end else begin
            wv_q <= wr_go;
            wa_q <= i_awaddr;
            wd_q <= i_wdata[7:0];
            if (wv_q && wa_q == OFS_ROUTE) begin
                route_q <= wd_q;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_lvl; wr_go && i_awaddr == OFS_LEVEL |-> ##2
        ((o_pin_level ^ $past(i_wdata[15:0], 2)) & msk) == 16'h0000;
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("level write not seen on pins");
    property p_setclr; wr_go && i_awaddr == OFS_SETCLR |-> ##2
        ((o_pin_level ^ (($past(o_pin_level, 2) & ~$past(i_wdata[31:16], 2))
        | $past(i_wdata[15:0], 2))) & msk) == 16'h0000;
    endproperty
    a_setclr: assert property (p_setclr)
        else $error("set or clear result wrong");
    property p_clronly; wr_go && i_awaddr == OFS_CLRONLY |-> ##2
        ((o_pin_level ^ ($past(o_pin_level, 2) & ~$past(i_wdata[15:0], 2)))
        & msk) == 16'h0000;
    endproperty
    a_clronly: assert property (p_clronly)
        else $error("clear-only result wrong");
    property p_key_rise;
        $rose(o_lock_key_bit) |-> $past(ar_lock) || $past(ar_lock, 2);
    endproperty
    a_key_rise: assert property (p_key_rise)
        else $error("key bit rose without a lock read");
    property p_key_hold; o_lock_key_bit |=> o_lock_key_bit; endproperty
    a_key_hold: assert property (p_key_hold)
        else $error("key bit dropped before reset");
    property p_key_rd0;
        ar_lock && !o_lock_key_bit |=> o_rvalid && !o_rdata[KEY_BIT];
    endproperty
    a_key_rd0: assert property (p_key_rd0)
        else $error("lock read with key clear returned key set");
    property p_strb;
        aw_w && i_wstrb != STRB_FULL |-> ##[1:2] o_bvalid
            && o_bresp == RESP_SLVERR;
    endproperty
    a_strb: assert property (p_strb)
        else $error("partial write not refused");
    property p_wo_zero; i_arvalid && o_arready && (i_araddr == OFS_SETCLR
        || i_araddr == OFS_CLRONLY) |=> o_rvalid && o_rdata == 32'h0000_0000;
    endproperty
    a_wo_zero: assert property (p_wo_zero)
        else $error("write-only register read nonzero");
    property p_event; msk != 16'hFFFF && $stable(route_q) |->
        o_pin_level[route_q[3:0]] == $past(i_cpu_event_pulse);
    endproperty
    a_event: assert property (p_event)
        else $error("event pulse not on routed pin");
    c_key: cover property ($rose(o_lock_key_bit));
    c_setclr: cover property (wr_go && i_awaddr == OFS_SETCLR);
    c_event: cover property (msk != 16'hFFFF && i_cpu_event_pulse);
endmodule
bind gole_top gole_props #(.PORT_ID(PORT_ID)) i_props (
    .i_clk_sys, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .o_bresp, .i_arvalid,
    .o_arready, .i_araddr, .o_rvalid, .o_rdata, .i_cpu_event_pulse,
    .o_pin_level, .o_lock_key_bit
);
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for gole_top
// Assumes: PORT_ID at 0, answers as in the hand-over timing
// Notes:   Bus answers are queued and checked by a monitor
`default_nettype none
module tb
    import gole_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0;
    logic        bre = 1'b0, arv = 1'b0, rre = 1'b0, ev = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd, md, cf;
    logic [3:0]  ws = 4'hF;
    logic        awr, wr, bv, arr, rv, key;
    logic [1:0]  br, rr;
    logic [15:0] pins, lv = 16'h0;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    int          num_errors = 0, tests_run = 0, cyc = 0;
    logic [7:0]  ofs [5] = '{OFS_ROUTE, OFS_LEVEL, OFS_SETCLR,
                             OFS_CLRONLY, OFS_LOCK};
    gole_top i_dut (
        .i_clk_sys(clk), .i_rst(rst), .i_awvalid(awv), .o_awready(awr),
        .i_awaddr(awa), .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wr),
        .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv), .i_bready(bre),
        .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
        .i_arprot(3'h0), .o_rvalid(rv), .i_rready(rre), .o_rdata(rd),
        .o_rresp(rr), .i_cpu_event_pulse(ev), .o_pin_level(pins),
        .o_pin_mode_field(md), .o_pin_cfg_field(cf), .o_lock_key_bit(key)
    );
    always #25 clk = ~clk;
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] e);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        exp_b.push_back(e);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        ws  <= s;
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awr) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (!dd && wr) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        while (!bv) @(posedge clk);
        bre <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        rre <= 1'b0;
    endtask
    // Monitor of bus answers and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rv && rre && exp_r.size() > 0) begin
            chk({rr, rd}, exp_r.pop_front());
        end
        if (bv && bre && exp_b.size() > 0) chk(br, exp_b.pop_front());
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        logic [31:0] r;
        logic [15:0] lk;
        logic        last;
        r = $urandom(76);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) rd_reg(ofs[i], 34'h0);
        rd_reg(8'h08, {RESP_SLVERR, 32'h0});
        wr_reg(OFS_LEVEL, 32'hFFFF, 4'h3, RESP_SLVERR);
        r = $urandom();
        wr_reg(OFS_LEVEL, r, STRB_FULL, RESP_OKAY);
        lv = r[15:0];
        rd_reg(OFS_LEVEL, {RESP_OKAY, 16'h0, lv});
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 32'hFFFF_FFFF : $urandom();
            if (i[0]) begin
                wr_reg(OFS_CLRONLY, r, STRB_FULL, RESP_OKAY);
                lv &= ~r[15:0];
            end else begin
                wr_reg(OFS_SETCLR, r, STRB_FULL, RESP_OKAY);
                lv = (lv & ~r[31:16]) | r[15:0];
            end
            chk(pins, lv);
        end
        for (int p = 0; p < 5; p++) begin
            r = $urandom();
            r[7:4] = {1'b1, 3'(p)};
            if (p == 0) r[3:0] = 4'hF;
            wr_reg(OFS_ROUTE, r, STRB_FULL, RESP_OKAY);
            rd_reg(OFS_ROUTE, {RESP_OKAY, 24'h0, r[7:0]});
            @(posedge clk);
            last = ev;
            repeat (6) begin
                @(posedge clk);
                chk(pins[r[3:0]], (p == 0) ? last : lv[r[3:0]]);
                last = ev;
                ev <= 1'($urandom());
            end
        end
        wr_reg(OFS_ROUTE, 32'h0, STRB_FULL, RESP_OKAY);
        chk(pins, lv);
        lk = 16'($urandom());
        for (int i = 0; i < 6; i++) begin
            r = {15'h0, i == 0 || i == 3 || i == 5, lk};
            wr_reg(OFS_LOCK, r, STRB_FULL, RESP_OKAY);
            if (i == 2) begin
                rd_reg(OFS_LOCK, {RESP_OKAY, 16'h0, lk});
                rd_reg(OFS_LOCK, {RESP_OKAY, 16'h0, lk});
            end
        end
        rd_reg(OFS_LOCK, {RESP_OKAY, 16'h0, lk});
        rd_reg(OFS_LOCK, {RESP_OKAY, 16'h1, lk});
        chk(key, 1'b1);
        wr_reg(OFS_LOCK, 32'h0, STRB_FULL, RESP_OKAY);
        rd_reg(OFS_LOCK, {RESP_OKAY, 16'h1, lk});
        wr_reg(OFS_CFG_LO, 32'hFFFF_FFFF, STRB_FULL, RESP_OKAY);
        wr_reg(OFS_CFG_HI, 32'hFFFF_FFFF, STRB_FULL, RESP_OKAY);
        for (int y = 0; y < 16; y++) begin
            chk({md[2*y+:2], cf[2*y+:2]}, lk[y] ? 4'h0 : 4'hF);
        end
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
